/* File: hdl/sched_timer_pkg.sv */
// Constants, codes and carrier types shared by the scheduled interrupt timer
`default_nettype none
package sched_timer_pkg;

    // ==========================================================
    // Clock and tick timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_10MS_NS = 10000000;
    localparam int TICK_1MS_NS = 1000000;
    localparam int TICK_100US_NS = 100000;
    localparam int TICK_10MS_CYC = TICK_10MS_NS / CLK_PERIOD_NS;
    localparam int TICK_1MS_CYC = TICK_1MS_NS / CLK_PERIOD_NS;
    localparam int TICK_100US_CYC = TICK_100US_NS / CLK_PERIOD_NS;

    // ==========================================================
    // Setup register
    localparam logic [7:0] TICK_UNIT_SETUP_OFS = 8'hC3;
    localparam int TICK_UNIT_LSB = 0;
    localparam int TICK_UNIT_W = 4;
    localparam logic [3:0] TICK_UNIT_RESET = 4'h0;

    typedef enum logic [3:0]
    {
        UNIT_10MS = 4'h0,
        UNIT_1MS = 4'h1,
        UNIT_100US = 4'h2
    } tick_unit_e;

    // ==========================================================
    // Instructions and interrupt identifiers
    typedef enum logic [1:0]
    {
        OP_SET_MASK = 2'b00,
        OP_READ_MASK = 2'b01,
        OP_CLEAR_PENDING = 2'b10,
        OP_IDLE = 2'b11
    } instr_op_e;

    localparam logic [7:0] ID_TMR0_NORMAL = 8'h04;
    localparam logic [7:0] ID_TMR1_NORMAL = 8'h05;
    localparam logic [7:0] ID_TMR0_RESET = 8'h0E;
    localparam logic [7:0] ID_TMR1_RESET = 8'h0F;

    // ==========================================================
    // Interval limits, in ticks
    localparam int INTERVAL_W = 14;
    localparam logic [15:0] INTERVAL_MAX = 16'h270F;
    localparam logic [15:0] INTERVAL_MIN_FINE = 16'h0005;
    localparam logic [15:0] INTERVAL_MIN_COARSE = 16'h0001;
    localparam logic [15:0] INTERVAL_PROHIBIT = 16'h0000;

    typedef struct packed
    {
        logic load;
        logic enable;
        logic clear_count;
        logic [INTERVAL_W-1:0] interval;
    } chan_cmd_s;

endpackage

`default_nettype wire

/* File: hdl/sched_channel.sv */
// One scheduled interrupt channel: interval, running count and interrupt pulse
`timescale 1ns/1ps
`default_nettype none

module sched_channel
    import sched_timer_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire chan_cmd_s cmd,
    output logic [INTERVAL_W-1:0] interval_q,
    output logic [INTERVAL_W-1:0] count_q,
    output logic irq
);

    // ==========================================================
    // Counting
    logic [INTERVAL_W-1:0] interval_reg;
    logic [INTERVAL_W-1:0] count_reg;
    logic enable_reg;
    logic irq_reg;
    wire logic [INTERVAL_W-1:0] count_inc;
    wire logic fire;

    assign count_inc = count_reg + 14'h0001;
    // A set-mask or clear-pending for this channel in the same cycle takes precedence over the tick
    assign fire = enable_reg & tick & ~cmd.load & ~cmd.clear_count & (count_inc >= interval_reg); // R3

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            interval_reg <= 14'h0000;
            count_reg <= 14'h0000;
            enable_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= fire; // R13
            if (cmd.load)
            begin
                interval_reg <= cmd.interval; // R3
                enable_reg <= cmd.enable; // R11
                if (cmd.clear_count)
                begin
                    count_reg <= 14'h0000; // R5
                end
            end
            else if (cmd.clear_count)
            begin
                count_reg <= 14'h0000;
            end
            else if (fire)
            begin
                count_reg <= 14'h0000; // R13
            end
            else if (enable_reg && tick)
            begin
                count_reg <= count_inc; // R7
            end
        end
    end

    assign interval_q = interval_reg;
    assign count_q = count_reg;
    assign irq = irq_reg;

endmodule

`default_nettype wire

/* File: hdl/sched_timer.sv */
// Two scheduled interrupt interval timers driven by program instructions
// Operation
// R1: Setup field selects tick: 0 is 10 ms, 1 is 1 ms, 2 is 0.1 ms.
// R2: With 0.1 ms tick, intervals 0.5 ms to 999.9 ms in 0.1 ms steps.
// R3: Set-mask value is the period between interrupts, in ticks.
// R4: Identifiers 4 and 5 start timer 0 or 1 keeping the count.
// R5: Identifiers 14 and 15 clear the count first, then start.
// R6: Program issues clear-pending when it needs a fixed first delay.
// R7: Running count measures from start or from the last interrupt.
// R8: Running count is in the same tick unit as the interval.
// R9: Read-mask with 4 or 5 returns the programmed interval.
// R10: Read-mask with 14 or 15 returns the running count.
// R11: Set-mask prohibit stops interrupts from that timer.
// R12: Tick unit setting takes effect only when operation starts.
// R13: Count reaching interval raises interrupt, clears count, counting continues.
`timescale 1ns/1ps
`default_nettype none

module sched_timer
    import sched_timer_pkg::*;
#(
    parameter int TICK_10MS_CYCLES = TICK_10MS_CYC,
    parameter int TICK_1MS_CYCLES = TICK_1MS_CYC,
    parameter int TICK_100US_CYCLES = TICK_100US_CYC
)
(
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic RUN,
    input wire logic CFG_WE,
    input wire logic [7:0] CFG_ADDR,
    input wire logic [3:0] CFG_WDATA,
    output logic [3:0] CFG_RDATA,
    input wire logic INSTR_VALID,
    input wire logic [1:0] INSTR_OP,
    input wire logic [7:0] INSTR_ID,
    input wire logic [15:0] INSTR_DATA,
    output logic RESP_VALID,
    output logic [15:0] RESP_DATA,
    output logic RESP_ERR,
    output logic [3:0] ACTIVE_UNIT,
    output logic [1:0] IRQ
);

    localparam int PRE_W = $clog2(TICK_10MS_CYCLES + 1);

    // ==========================================================
    // Parameter checks
    generate
        if (TICK_100US_CYCLES < 1 || TICK_1MS_CYCLES < TICK_100US_CYCLES || TICK_10MS_CYCLES < TICK_1MS_CYCLES)
        begin : g_bad_tick
            $error("sched_timer: tick cycle counts must be ordered and at least one");
        end
    endgenerate

    // ==========================================================
    // Decoding helpers
    // Returns {known, reset_start, timer index}
    function automatic logic [2:0] decode_id(input logic [7:0] id);
        logic [2:0] r;
        r = 3'b000;
        case (id)
            ID_TMR0_NORMAL: r = 3'b100;
            ID_TMR1_NORMAL: r = 3'b101;
            ID_TMR0_RESET: r = 3'b110;
            ID_TMR1_RESET: r = 3'b111;
            default: r = 3'b000;
        endcase
        return r;
    endfunction

    function automatic logic interval_ok(input logic [15:0] value, input logic [3:0] unit);
        logic [15:0] min_val;
        min_val = (unit == UNIT_100US) ? INTERVAL_MIN_FINE : INTERVAL_MIN_COARSE; // R2
        return (value == INTERVAL_PROHIBIT) || ((value >= min_val) && (value <= INTERVAL_MAX));
    endfunction

    // ==========================================================
    // Tick unit setup register and start of operation
    logic [3:0] setup_reg;
    logic [3:0] active_unit_reg;
    logic run_prev_reg;
    logic [3:0] cfg_rdata_reg;
    wire logic cfg_hit;
    wire logic run_start;
    wire logic [3:0] setup_legal;

    assign cfg_hit = (CFG_ADDR == TICK_UNIT_SETUP_OFS);
    assign run_start = RUN & ~run_prev_reg;
    // Codes above 2 are not defined; they fall back to the default tick
    assign setup_legal = (setup_reg == UNIT_1MS || setup_reg == UNIT_100US) ? setup_reg : TICK_UNIT_RESET; // R1

    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            setup_reg <= TICK_UNIT_RESET;
            active_unit_reg <= TICK_UNIT_RESET;
            run_prev_reg <= 1'b0;
            cfg_rdata_reg <= 4'h0;
        end
        else
        begin
            run_prev_reg <= RUN;
            if (CFG_WE && cfg_hit)
            begin
                setup_reg <= CFG_WDATA[TICK_UNIT_LSB +: TICK_UNIT_W];
            end
            if (run_start)
            begin
                active_unit_reg <= setup_legal; // R12
            end
            cfg_rdata_reg <= cfg_hit ? setup_reg : 4'h0;
        end
    end

    // ==========================================================
    // Tick prescaler
    logic [PRE_W-1:0] pre_reg;
    logic tick_reg;
    wire logic [PRE_W-1:0] pre_limit;
    wire logic pre_wrap;

    assign pre_limit = (active_unit_reg == UNIT_100US) ? PRE_W'(TICK_100US_CYCLES - 1) :
                       (active_unit_reg == UNIT_1MS) ? PRE_W'(TICK_1MS_CYCLES - 1) :
                       PRE_W'(TICK_10MS_CYCLES - 1); // R1
    assign pre_wrap = (pre_reg >= pre_limit);

    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            pre_reg <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            // The prescaler restarts with operation so the new unit begins cleanly
            if (!RUN || run_start || pre_wrap)
            begin
                pre_reg <= '0;
            end
            else
            begin
                pre_reg <= pre_reg + PRE_W'(1);
            end
            tick_reg <= RUN & ~run_start & pre_wrap;
        end
    end

    // ==========================================================
    // Instruction decode
    wire logic [2:0] id_dec;
    wire logic id_known;
    wire logic id_reset;
    wire logic id_idx;
    wire logic op_set;
    wire logic op_read;
    wire logic op_clear;
    wire logic set_good;
    wire logic cmd_err;

    assign id_dec = decode_id(INSTR_ID);
    assign id_known = id_dec[2];
    assign id_reset = id_dec[1];
    assign id_idx = id_dec[0];
    assign op_set = INSTR_VALID && (INSTR_OP == OP_SET_MASK) && id_known;
    assign op_read = INSTR_VALID && (INSTR_OP == OP_READ_MASK) && id_known;
    assign op_clear = INSTR_VALID && (INSTR_OP == OP_CLEAR_PENDING) && id_known;
    assign set_good = op_set && interval_ok(INSTR_DATA, active_unit_reg); // R2
    assign cmd_err = INSTR_VALID && (!id_known || (INSTR_OP == OP_IDLE) || (op_set && !set_good));

    // ==========================================================
    // Channels
    wire chan_cmd_s cmd [2];
    wire logic [INTERVAL_W-1:0] interval_q [2];
    wire logic [INTERVAL_W-1:0] count_q [2];
    wire logic [1:0] irq_w;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_chan
            wire logic sel;
            assign sel = (id_idx == 1'(gi));
            assign cmd[gi].load = set_good && sel; // R4
            assign cmd[gi].enable = (INSTR_DATA != INTERVAL_PROHIBIT); // R11
            assign cmd[gi].clear_count = sel && ((set_good && id_reset) || op_clear); // R5 R6
            assign cmd[gi].interval = INSTR_DATA[INTERVAL_W-1:0];

            sched_channel u_chan
            (
                .clk(MCLK),
                .rst_n(NRST),
                .tick(tick_reg),
                .cmd(cmd[gi]),
                .interval_q(interval_q[gi]),
                .count_q(count_q[gi]),
                .irq(irq_w[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Responses
    logic resp_valid_reg;
    logic [15:0] resp_data_reg;
    logic resp_err_reg;
    logic [1:0] irq_reg;
    wire logic [INTERVAL_W-1:0] read_sel;

    // Count is in ticks of the active unit, same as the interval
    assign read_sel = id_reset ? count_q[id_idx] : interval_q[id_idx]; // R8 R9 R10

    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            resp_valid_reg <= 1'b0;
            resp_data_reg <= 16'h0000;
            resp_err_reg <= 1'b0;
            irq_reg <= 2'b00;
        end
        else
        begin
            resp_valid_reg <= INSTR_VALID;
            resp_err_reg <= cmd_err;
            resp_data_reg <= op_read ? {2'b00, read_sel} : 16'h0000; // R9 R10
            irq_reg <= irq_w; // R13
        end
    end

    assign CFG_RDATA = cfg_rdata_reg;
    assign RESP_VALID = resp_valid_reg;
    assign RESP_DATA = resp_data_reg;
    assign RESP_ERR = resp_err_reg;
    assign ACTIVE_UNIT = active_unit_reg;
    assign IRQ = irq_reg;

endmodule

`default_nettype wire

/* File: tb/sched_timer_sva.sv */
// Port-level assertions for the scheduled interrupt timer
`timescale 1ns/1ps
`default_nettype none
module sched_timer_sva
    import sched_timer_pkg::*;
(
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic RUN,
    input wire logic [7:0] CFG_ADDR,
    input wire logic [3:0] CFG_RDATA,
    input wire logic INSTR_VALID,
    input wire logic [1:0] INSTR_OP,
    input wire logic [7:0] INSTR_ID,
    input wire logic [15:0] INSTR_DATA,
    input wire logic RESP_VALID,
    input wire logic [15:0] RESP_DATA,
    input wire logic RESP_ERR,
    input wire logic [3:0] ACTIVE_UNIT,
    input wire logic [1:0] IRQ
);
    // ==========================================
    // Helpers
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);
    wire logic is_set = INSTR_VALID && INSTR_OP == OP_SET_MASK;
    wire logic in_rng = INSTR_DATA >= INTERVAL_MIN_FINE && INSTR_DATA <= INTERVAL_MAX;
    wire logic fine = ACTIVE_UNIT == UNIT_100US;
    wire logic id_ok = INSTR_ID inside {ID_TMR0_NORMAL, ID_TMR1_NORMAL, ID_TMR0_RESET, ID_TMR1_RESET};
    sequence s_set(logic [7:0] id); is_set && INSTR_ID == id && in_rng; endsequence
    sequence s_read(logic [7:0] id); INSTR_VALID && INSTR_OP == OP_READ_MASK && INSTR_ID == id; endsequence

    // ==========================================
    // Properties
    property p_answer; INSTR_VALID |=> RESP_VALID; endproperty
    a_answer: assert property (p_answer) else $error("no response after instruction");
    property p_fine_err; is_set && fine && INSTR_DATA != INTERVAL_PROHIBIT && !in_rng |=> RESP_ERR; endproperty
    a_fine_err: assert property (p_fine_err) else $error("fine interval outside range accepted");
    property p_fine_ok; is_set && fine && id_ok && in_rng |=> !RESP_ERR; endproperty
    a_fine_ok: assert property (p_fine_ok) else $error("fine interval inside range refused");
    property p_interval; s_set(ID_TMR0_NORMAL) ##1 s_read(ID_TMR0_NORMAL) |=> RESP_DATA == $past(INSTR_DATA, 2); endproperty
    a_interval: assert property (p_interval) else $error("read back interval differs");
    property p_cleared; s_set(ID_TMR0_RESET) ##1 s_read(ID_TMR0_RESET) |=> RESP_DATA == 16'h0000; endproperty
    a_cleared: assert property (p_cleared) else $error("count not cleared by reset start");
    property p_unit_hold; RUN [*3] |-> $stable(ACTIVE_UNIT); endproperty
    a_unit_hold: assert property (p_unit_hold) else $error("tick unit changed while running");
    property p_irq_pulse; IRQ[0] |=> !IRQ[0]; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than one cycle");
    property p_halt; !RUN [*5] |-> IRQ == 2'b00; endproperty
    a_halt: assert property (p_halt) else $error("interrupt while stopped");
    property p_unmapped; CFG_ADDR != TICK_UNIT_SETUP_OFS |=> CFG_RDATA == 4'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped address read nonzero");
endmodule
bind sched_timer sched_timer_sva sched_timer_sva_inst (.MCLK, .NRST, .RUN, .CFG_ADDR, .CFG_RDATA, .INSTR_VALID,
    .INSTR_OP, .INSTR_ID, .INSTR_DATA, .RESP_VALID, .RESP_DATA, .RESP_ERR, .ACTIVE_UNIT, .IRQ);
`default_nettype wire

/* File: tb/sched_timer_tb.sv */
// Self-checking bench for the scheduled interrupt timer
`timescale 1ns/1ps
`default_nettype none
module sched_timer_tb
    import sched_timer_pkg::*;
;
    // ==========================================
    // Stimulus and design
    logic MCLK = 0, NRST = 0, RUN = 0, CFG_WE = 0, INSTR_VALID = 0, RESP_VALID, RESP_ERR, re;
    logic [7:0] CFG_ADDR = 0, INSTR_ID = 0;
    logic [3:0] CFG_WDATA = 0, CFG_RDATA, ACTIVE_UNIT, rdv;
    logic [1:0] INSTR_OP = 0, IRQ;
    logic [15:0] INSTR_DATA = 0, RESP_DATA, rd;
    int fail_count = 0, total_checks = 0, cycles = 0, c;
    // Short ticks keep the run brief; periods are derived from these
    localparam int TK[3] = '{40, 20, 4};
    localparam logic [1:0] OPS[7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h0, 2'h1};
    localparam logic [7:0] IDS[7] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h07, 8'h09};
    localparam logic [15:0] DAT[7] = '{16'h0004, 16'h0005, 16'h270F, 16'h2710, 16'h0005, 16'h0005, 16'h0000};
    localparam logic ERRS[7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

    sched_timer #(.TICK_10MS_CYCLES(40), .TICK_1MS_CYCLES(20), .TICK_100US_CYCLES(4)) sched_timer_inst (.MCLK, .NRST,
        .RUN, .CFG_WE, .CFG_ADDR, .CFG_WDATA, .CFG_RDATA, .INSTR_VALID, .INSTR_OP, .INSTR_ID, .INSTR_DATA,
        .RESP_VALID, .RESP_DATA, .RESP_ERR, .ACTIVE_UNIT, .IRQ);

    initial
    begin
        forever #20 MCLK = ~MCLK;
    end

    always @(posedge MCLK)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            fail_count++;
            conclude;
        end
    end

    // ==========================================
    // Shared tasks
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("BAD %s expected %0h seen %0h", n, e, g);
        end
    endtask

    task rng(input string n, input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] v);
        chk(n, 16'h0001, {15'h0, v >= lo && v <= hi});
    endtask

    task cfg(input logic [7:0] a, input logic [3:0] d, input logic we);
        @(negedge MCLK);
        CFG_WE = we;
        CFG_ADDR = a;
        CFG_WDATA = d;
        @(negedge MCLK);
        CFG_WE = 1'b0;
        rdv = CFG_RDATA;
    endtask

    task send(input logic [1:0] op, input logic [7:0] id, input logic [15:0] d);
        @(negedge MCLK);
        INSTR_VALID = 1'b1;
        INSTR_OP = op;
        INSTR_ID = id;
        INSTR_DATA = d;
        @(negedge MCLK);
        // The answer stands for one cycle only, so take it before releasing
        re = RESP_ERR;
        rd = RESP_DATA;
        chk("resp_valid", 16'h0001, {15'h0, RESP_VALID});
        INSTR_VALID = 1'b0;
    endtask

    task wait_irq(input int b);
        c = 0;
        do
        begin
            @(negedge MCLK);
            c++;
        end
        while (IRQ[b] !== 1'b1 && c < 2000);
    endtask

    // ==========================================
    // Scenarios
    task t_regs;
        chk("unit_rst", 16'h0000, {12'h0, ACTIVE_UNIT});
        cfg(TICK_UNIT_SETUP_OFS, 4'h0, 1'b0);
        chk("setup_rst", {12'h0, TICK_UNIT_RESET}, {12'h0, rdv});
        cfg(TICK_UNIT_SETUP_OFS, 4'h1, 1'b1);
        cfg(8'h10, 4'hF, 1'b1);
        chk("unmapped", 16'h0000, {12'h0, rdv});
        cfg(TICK_UNIT_SETUP_OFS, 4'h0, 1'b0);
        chk("setup_rw", 16'h0001, {12'h0, rdv});
    endtask

    task t_units;
        for (int u = 0; u < 3; u++)
        begin
            @(negedge MCLK);
            RUN = 1'b0;
            // Long enough for the stopped-timer check to see a halt
            repeat (6) @(negedge MCLK);
            cfg(TICK_UNIT_SETUP_OFS, u[3:0], 1'b1);
            RUN = 1'b1;
            repeat (2) @(negedge MCLK);
            chk("unit", {12'h0, u[3:0]}, {12'h0, ACTIVE_UNIT});
            cfg(TICK_UNIT_SETUP_OFS, 4'h3 - u[3:0], 1'b1);
            chk("unit_held", {12'h0, u[3:0]}, {12'h0, ACTIVE_UNIT});
            send(OP_SET_MASK, ID_TMR1_NORMAL, 16'h0001);
            chk("min_err", {15'h0, u == 2}, {15'h0, re});
            send(OP_SET_MASK, ID_TMR0_RESET, 16'h0005);
            chk("start_err", 16'h0000, {15'h0, re});
            wait_irq(0);
            rng("first_irq", 16'(4 * TK[u]), 16'(5 * TK[u] + 3), 16'(c));
            wait_irq(0);
            chk("period", 16'(5 * TK[u]), 16'(c));
        end
    endtask

    task t_range;
        for (int i = 0; i < 7; i++)
        begin
            send(OPS[i], IDS[i], DAT[i]);
            chk("range_err", {15'h0, ERRS[i]}, {15'h0, re});
        end
    endtask

    task t_count;
        send(OP_SET_MASK, ID_TMR1_RESET, 16'h0032);
        send(OP_READ_MASK, ID_TMR1_NORMAL, 16'h0000);
        chk("interval", 16'h0032, rd);
        repeat (40) @(negedge MCLK);
        send(OP_READ_MASK, ID_TMR1_RESET, 16'h0000);
        rng("count", 16'h000A, 16'h000C, rd);
        send(OP_SET_MASK, ID_TMR1_NORMAL, 16'h0032);
        send(OP_READ_MASK, ID_TMR1_RESET, 16'h0000);
        rng("count_kept", 16'h000A, 16'h000D, rd);
        send(OP_CLEAR_PENDING, ID_TMR1_NORMAL, 16'h0000);
        send(OP_READ_MASK, ID_TMR1_RESET, 16'h0000);
        rng("count_cleared", 16'h0000, 16'h0001, rd);
        wait_irq(1);
        rng("delay_after_clear", 16'h00BE, 16'h00CC, 16'(c));
        send(OP_READ_MASK, ID_TMR1_RESET, 16'h0000);
        rng("count_after_irq", 16'h0000, 16'h0001, rd);
    endtask

    task t_b2b(input logic [7:0] id);
        @(negedge MCLK);
        INSTR_VALID = 1'b1;
        INSTR_OP = OP_SET_MASK;
        INSTR_ID = id;
        INSTR_DATA = 16'h0014;
        @(negedge MCLK);
        INSTR_OP = OP_READ_MASK;
        @(negedge MCLK);
        chk("b2b_read", id == ID_TMR0_NORMAL ? 16'h0014 : 16'h0000, RESP_DATA);
        INSTR_VALID = 1'b0;
    endtask

    task t_prohibit;
        send(OP_SET_MASK, ID_TMR0_NORMAL, INTERVAL_PROHIBIT);
        chk("off_err", 16'h0000, {15'h0, re});
        send(OP_SET_MASK, ID_TMR1_NORMAL, INTERVAL_PROHIBIT);
        c = 0;
        repeat (400)
        begin
            @(negedge MCLK);
            if (IRQ !== 2'b00)
                c++;
        end
        chk("irq_after_off", 16'h0000, 16'(c));
    endtask

    task conclude;
        if (fail_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(negedge MCLK);
        NRST = 1'b1;
        t_regs;
        t_units;
        t_range;
        t_count;
        t_b2b(ID_TMR0_NORMAL);
        t_b2b(ID_TMR0_RESET);
        t_prohibit;
        conclude;
    end
endmodule
`default_nettype wire
